//--- hdl/urf_pkg.sv
// Functional notes
// - Flag register is eight bits, one flag per bit, bit 5 holds nothing.
// - Carry bit 0 set by add carry-out, set-carry op, cleared by clear-carry op.
// - Zero bit 1 set when a result is zero, cleared otherwise.
// - Branch-if-zero jumps relative to PC when zero set; nonzero branch is opposite.
// - Mask bit 2 set by set-mask op, cleared by clear-mask op.
// - Decimal bit 3 set by set-decimal op, cleared by clear-decimal op.
// - Break bit 4 becomes 1 when the software break op executes.
// - Break and interrupt push the PC, then push the flags on top.
// - Software break saves its own PC plus two as return address.
// - Pushed break bit is set for software break, clear for hardware interrupt.
// - Overflow bit 6 set on signed overflow, cleared by op, set by bit-test.
// - Overflow-set branch takes on 1, overflow-clear branch takes on 0.
// - Negative bit 7 set on negative result; minus and plus branches test it.
// - Branches test three flags; taken when true, else continue after branch.
// - Indexed effective address is base address plus selected index register.
// - Add results are written into the accumulator; increment writes X, and compare writes only the flags.
// - Store ops take data only from accumulator or an index register; stack pushes write PC bytes and flags.
// - Both index registers load and store like the accumulator.
// - Copy op moves accumulator to X; increment adds 1; compare updates flags.
// - Program counter is 16 bits and advances sequentially.
// - Stack lives at 256 to 511, last-in first-out, tracked by pointer.
// - Calls and interrupts push the return address; returns pop it; the return op pops two bytes and no flags, so it fits calls only.
package urf_pkg;

  // ----------------------------------------
  // Flag field positions
  // ----------------------------------------
  localparam int FLAG_CARRY    = 0;
  localparam int FLAG_ZERO     = 1;
  localparam int FLAG_MASK     = 2;
  localparam int FLAG_DECIMAL  = 3;
  localparam int FLAG_BREAK    = 4;
  localparam int FLAG_UNUSED   = 5;
  localparam int FLAG_OVERFLOW = 6;
  localparam int FLAG_NEGATIVE = 7;

  // ----------------------------------------
  // Reset values and fixed numbers
  // ----------------------------------------
  localparam logic [7:0]  FLAGS_RESET    = 8'h04;
  localparam logic [7:0]  DATA_RESET     = 8'h00;
  localparam logic [7:0]  SP_RESET       = 8'hFF;
  localparam logic [15:0] PC_RESET       = 16'h0000;
  localparam logic [7:0]  STACK_PAGE     = 8'h01;
  localparam logic [15:0] BREAK_RET_STEP = 16'h0002;

  typedef enum logic [4:0] {
    URF_NOP, URF_LOAD_ACC, URF_LOAD_X, URF_LOAD_Y, URF_STORE_ACC, URF_STORE_X, URF_STORE_Y,
    URF_ADD, URF_BIT_TEST, URF_SET_CARRY, URF_CLEAR_CARRY, URF_SET_MASK, URF_CLEAR_MASK,
    URF_SET_DECIMAL, URF_CLEAR_DECIMAL, URF_CLEAR_OVERFLOW, URF_COPY_ACC_X, URF_INC_X,
    URF_COMPARE_X, URF_BR_ZERO, URF_BR_NONZERO, URF_BR_OVF_SET, URF_BR_OVF_CLEAR,
    URF_BR_NEG, URF_BR_POS, URF_CALL, URF_RETURN, URF_BREAK
  } urf_op_t;

  typedef enum logic [1:0] {
    URF_IDX_NONE, URF_IDX_X, URF_IDX_Y
  } urf_idx_t;

  typedef enum logic [2:0] {
    URF_IDLE, URF_PUSH_LO, URF_PUSH_FLAGS, URF_POP_LO, URF_POP_HI
  } urf_mode_t;

endpackage

//--- hdl/urf_core.sv
`timescale 1ns/1ps
module urf_core (
  input  wire logic             mclk_in,
  input  wire logic             rst_in,
  input  wire logic             ce_in,
  input  wire logic             op_valid_in,
  input  wire urf_pkg::urf_op_t op_in,
  input  wire urf_pkg::urf_idx_t idx_sel_in,
  input  wire logic [7:0]       operand_in,
  input  wire logic [15:0]      base_addr_in,
  input  wire logic [1:0]       op_len_in,
  input  wire logic [15:0]      vector_in,
  input  wire logic [7:0]       mem_rdata_in,
  input  wire logic             irq_in,
  output logic                  ready_out,
  output logic [7:0]            acc_out,
  output logic [7:0]            x_out,
  output logic [7:0]            y_out,
  output logic [7:0]            flags_out,
  output logic [7:0]            sp_out,
  output logic [15:0]           pc_out,
  output logic [15:0]           mem_addr_out,
  output logic [7:0]            mem_wdata_out,
  output logic                  mem_we_out,
  output logic                  branch_taken_out
);
  import urf_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    urf_mode_t   mode;
    logic [2:0]  sync;
    logic        irq_lvl;
    logic [7:0]  acc;
    logic [7:0]  x;
    logic [7:0]  y;
    logic [7:0]  flags;
    logic [7:0]  sp;
    logic [15:0] pc;
    logic [15:0] ret;
    logic [15:0] vec;
    logic [7:0]  push_flags;
    logic        with_flags;
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        we;
    logic        taken;
    logic        ready;
  } urf_state_t;

  urf_state_t st;
  urf_state_t next_st;

  logic        take;
  logic        irq_take;
  logic [15:0] seq_pc;
  logic [15:0] br_target;
  logic [15:0] eff_addr;
  logic [7:0]  idx_val;
  logic [8:0]  sum;
  logic [8:0]  cmp;
  logic        cond;
  logic [15:0] brk_ret;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  assign take      = ce_in && op_valid_in && st.ready && (st.mode == URF_IDLE);
  assign irq_take  = ce_in && !take && (st.mode == URF_IDLE) && st.irq_lvl &&
                     !st.flags[FLAG_MASK];
  assign seq_pc    = st.pc + {14'h0000, op_len_in};
  assign br_target = seq_pc + {{8{operand_in[7]}}, operand_in};
  assign idx_val   = (idx_sel_in == URF_IDX_X) ? st.x :
                     (idx_sel_in == URF_IDX_Y) ? st.y : 8'h00;
  assign eff_addr  = base_addr_in + {8'h00, idx_val};
  assign sum       = {1'b0, st.acc} + {1'b0, operand_in} + {8'h00, st.flags[FLAG_CARRY]};
  assign cmp       = {1'b0, st.x} - {1'b0, operand_in};
  assign brk_ret   = st.pc + BREAK_RET_STEP;

  // Three flags steer the six conditional branches.
  always_comb begin
    case (op_in)
      URF_BR_ZERO:      cond = st.flags[FLAG_ZERO];
      URF_BR_NONZERO:   cond = !st.flags[FLAG_ZERO];
      URF_BR_OVF_SET:   cond = st.flags[FLAG_OVERFLOW];
      URF_BR_OVF_CLEAR: cond = !st.flags[FLAG_OVERFLOW];
      URF_BR_NEG:       cond = st.flags[FLAG_NEGATIVE];
      URF_BR_POS:       cond = !st.flags[FLAG_NEGATIVE];
      default:          cond = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    next_st       = st;
    next_st.sync  = {st.sync[1:0], irq_in};
    next_st.we    = 1'b0;
    next_st.taken = 1'b0;
    // Two later stages must agree, so a glitch on the pin is not seen as a request.
    if (st.sync[1] == st.sync[2]) begin
      next_st.irq_lvl = st.sync[2];
    end
    case (st.mode)
      URF_IDLE: begin
        if (irq_take) begin
          next_st.addr       = {STACK_PAGE, st.sp};
          next_st.wdata      = st.pc[15:8];
          next_st.we         = 1'b1;
          next_st.sp         = st.sp - 8'h01;
          next_st.ret        = st.pc;
          next_st.vec        = vector_in;
          next_st.with_flags = 1'b1;
          next_st.push_flags = st.flags & ~(8'h01 << FLAG_BREAK);
          next_st.flags[FLAG_MASK] = 1'b1;
          next_st.mode       = URF_PUSH_LO;
        end else if (take) begin
          next_st.pc = seq_pc;
          case (op_in)
            URF_LOAD_ACC: begin
              next_st.acc = operand_in;
              next_st.flags[FLAG_ZERO]     = (operand_in == 8'h00);
              next_st.flags[FLAG_NEGATIVE] = operand_in[7];
            end
            URF_LOAD_X: begin
              next_st.x = operand_in;
              next_st.flags[FLAG_ZERO]     = (operand_in == 8'h00);
              next_st.flags[FLAG_NEGATIVE] = operand_in[7];
            end
            URF_LOAD_Y: begin
              next_st.y = operand_in;
              next_st.flags[FLAG_ZERO]     = (operand_in == 8'h00);
              next_st.flags[FLAG_NEGATIVE] = operand_in[7];
            end
            URF_STORE_ACC, URF_STORE_X, URF_STORE_Y: begin
              next_st.addr = eff_addr;
              next_st.we   = 1'b1;
              if (op_in == URF_STORE_ACC) begin
                next_st.wdata = st.acc;
              end else if (op_in == URF_STORE_X) begin
                next_st.wdata = st.x;
              end else begin
                next_st.wdata = st.y;
              end
            end
            URF_ADD: begin
              // Decimal mode is held as a flag only; the adder stays binary.
              next_st.acc = sum[7:0];
              next_st.flags[FLAG_CARRY]    = sum[8];
              next_st.flags[FLAG_ZERO]     = (sum[7:0] == 8'h00);
              next_st.flags[FLAG_NEGATIVE] = sum[7];
              next_st.flags[FLAG_OVERFLOW] =
                (st.acc[7] ^ sum[7]) & (operand_in[7] ^ sum[7]);
            end
            URF_BIT_TEST: begin
              next_st.flags[FLAG_ZERO]     = ((st.acc & operand_in) == 8'h00);
              next_st.flags[FLAG_OVERFLOW] = operand_in[6];
              next_st.flags[FLAG_NEGATIVE] = operand_in[7];
            end
            URF_SET_CARRY:      next_st.flags[FLAG_CARRY]    = 1'b1;
            URF_CLEAR_CARRY:    next_st.flags[FLAG_CARRY]    = 1'b0;
            URF_SET_MASK:       next_st.flags[FLAG_MASK]     = 1'b1;
            URF_CLEAR_MASK:     next_st.flags[FLAG_MASK]     = 1'b0;
            URF_SET_DECIMAL:    next_st.flags[FLAG_DECIMAL]  = 1'b1;
            URF_CLEAR_DECIMAL:  next_st.flags[FLAG_DECIMAL]  = 1'b0;
            URF_CLEAR_OVERFLOW: next_st.flags[FLAG_OVERFLOW] = 1'b0;
            URF_COPY_ACC_X: begin
              next_st.x = st.acc;
              next_st.flags[FLAG_ZERO]     = (st.acc == 8'h00);
              next_st.flags[FLAG_NEGATIVE] = st.acc[7];
            end
            URF_INC_X: begin
              next_st.x = st.x + 8'h01;
              next_st.flags[FLAG_ZERO]     = (st.x == 8'hFF);
              next_st.flags[FLAG_NEGATIVE] = next_st.x[7];
            end
            URF_COMPARE_X: begin
              next_st.flags[FLAG_CARRY]    = !cmp[8];
              next_st.flags[FLAG_ZERO]     = (cmp[7:0] == 8'h00);
              next_st.flags[FLAG_NEGATIVE] = cmp[7];
            end
            URF_BR_ZERO, URF_BR_NONZERO, URF_BR_OVF_SET, URF_BR_OVF_CLEAR,
            URF_BR_NEG, URF_BR_POS: begin
              next_st.taken = cond;
              if (cond) begin
                next_st.pc = br_target;
              end
            end
            URF_CALL: begin
              next_st.addr       = {STACK_PAGE, st.sp};
              next_st.wdata      = seq_pc[15:8];
              next_st.we         = 1'b1;
              next_st.sp         = st.sp - 8'h01;
              next_st.ret        = seq_pc;
              next_st.with_flags = 1'b0;
              next_st.pc         = base_addr_in;
              next_st.mode       = URF_PUSH_LO;
            end
            URF_RETURN: begin
              next_st.sp   = st.sp + 8'h01;
              next_st.addr = {STACK_PAGE, st.sp + 8'h01};
              next_st.mode = URF_POP_LO;
            end
            URF_BREAK: begin
              next_st.addr       = {STACK_PAGE, st.sp};
              next_st.wdata      = brk_ret[15:8];
              next_st.we         = 1'b1;
              next_st.sp         = st.sp - 8'h01;
              next_st.ret        = brk_ret;
              next_st.vec        = vector_in;
              next_st.with_flags = 1'b1;
              next_st.flags[FLAG_BREAK] = 1'b1;
              next_st.flags[FLAG_MASK]  = 1'b1;
              next_st.push_flags = st.flags | (8'h01 << FLAG_BREAK);
              next_st.mode       = URF_PUSH_LO;
            end
            default: begin
            end
          endcase
        end
      end
      URF_PUSH_LO: begin
        next_st.addr  = {STACK_PAGE, st.sp};
        next_st.wdata = st.ret[7:0];
        next_st.we    = 1'b1;
        next_st.sp    = st.sp - 8'h01;
        next_st.mode  = st.with_flags ? URF_PUSH_FLAGS : URF_IDLE;
      end
      URF_PUSH_FLAGS: begin
        next_st.addr  = {STACK_PAGE, st.sp};
        next_st.wdata = st.push_flags;
        next_st.we    = 1'b1;
        next_st.sp    = st.sp - 8'h01;
        next_st.pc    = st.vec;
        next_st.mode  = URF_IDLE;
      end
      URF_POP_LO: begin
        next_st.ret[7:0] = mem_rdata_in;
        next_st.sp       = st.sp + 8'h01;
        next_st.addr     = {STACK_PAGE, st.sp + 8'h01};
        next_st.mode     = URF_POP_HI;
      end
      URF_POP_HI: begin
        next_st.pc   = {mem_rdata_in, st.ret[7:0]};
        next_st.mode = URF_IDLE;
      end
      default: next_st.mode = URF_IDLE;
    endcase
    next_st.flags[FLAG_UNUSED] = 1'b0;
    next_st.ready = (next_st.mode == URF_IDLE) &&
                    !(next_st.irq_lvl && !next_st.flags[FLAG_MASK]);
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st <= '{mode: URF_IDLE, sync: 3'h0, irq_lvl: 1'b0, acc: DATA_RESET, x: DATA_RESET,
              y: DATA_RESET, flags: FLAGS_RESET, sp: SP_RESET, pc: PC_RESET,
              ret: PC_RESET, vec: PC_RESET, push_flags: DATA_RESET, with_flags: 1'b0,
              addr: PC_RESET, wdata: DATA_RESET, we: 1'b0, taken: 1'b0, ready: 1'b0};
    end else if (ce_in) begin
      st <= next_st;
    end
  end

  assign ready_out        = st.ready;
  assign acc_out          = st.acc;
  assign x_out            = st.x;
  assign y_out            = st.y;
  assign flags_out        = st.flags;
  assign sp_out           = st.sp;
  assign pc_out           = st.pc;
  assign mem_addr_out     = st.addr;
  assign mem_wdata_out    = st.wdata;
  assign mem_we_out       = st.we;
  assign branch_taken_out = st.taken;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  a_bit5_empty: assert property (@(posedge mclk_in) disable iff (rst_in)
    !st.flags[FLAG_UNUSED]) else $error("Flag bit 5 is set.");
  a_set_carry_only: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && op_in == URF_SET_CARRY |=> st.flags == ($past(st.flags) | 8'h01))
    else $error("Set-carry changed more than the carry bit.");
  a_load_zero_flag: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && op_in == URF_LOAD_ACC |=> st.flags[FLAG_ZERO] == (st.acc == 8'h00))
    else $error("Zero flag disagrees with loaded value.");
  a_branch_zero_pc: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && op_in == URF_BR_ZERO |=>
      st.pc == ($past(st.flags[FLAG_ZERO]) ? $past(br_target) : $past(seq_pc)))
    else $error("Zero branch went to the wrong address.");
  a_break_ret_addr: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && op_in == URF_BREAK |=>
      st.we && st.wdata == $past(st.pc + BREAK_RET_STEP) >> 8 ##1
      st.we && st.wdata == $past(st.pc + BREAK_RET_STEP, 2) % 256)
    else $error("Break pushed a wrong return address.");
  a_push_flag_cause: assert property (@(posedge mclk_in) disable iff (rst_in)
    (take && op_in == URF_BREAK) || irq_take |=> ##2
      st.we && st.wdata[FLAG_BREAK] == $past(take, 3))
    else $error("Pushed break bit does not match the cause.");
  a_store_source: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && op_in == URF_STORE_X |=> st.we && st.wdata == $past(st.x))
    else $error("Store data did not come from X.");
  a_index_address: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && op_in == URF_STORE_ACC |=> st.addr == $past(eff_addr) && st.wdata == $past(st.acc))
    else $error("Indexed store address is wrong.");
  a_stack_page: assert property (@(posedge mclk_in) disable iff (rst_in)
    st.mode == URF_PUSH_LO |-> st.we && st.addr[15:8] == STACK_PAGE)
    else $error("Stack write left the stack page.");
  a_inc_x: assert property (@(posedge mclk_in) disable iff (rst_in)
    take && op_in == URF_INC_X |=> st.x == $past(st.x) + 8'h01)
    else $error("Increment of X is wrong.");

endmodule

//--- testbench/urf_mem_model.sv
`timescale 1ns/1ps
module urf_mem_model (
  input  wire logic        mclk_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [7:0]  wdata_in,
  input  wire logic        we_in,
  output logic [7:0]       rdata_out
);
  // Cells start with a pattern, so that a stored zero stands out from an untouched cell.
  logic [7:0] mem [0:65535];
  initial begin
    for (int i = 0; i < 65536; i++) begin
      mem[i] = 8'hA5;
    end
  end
  // Pops read in the cycle the address shows, so read data follows the address at once.
  assign rdata_out = mem[addr_in];
  always @(posedge mclk_in) begin
    if (we_in) begin
      mem[addr_in] <= wdata_in;
    end
  end
endmodule

//--- testbench/tb_top.sv
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, (a), (b)); end end
module tb_top;
  import urf_pkg::*;
  typedef struct packed {
    urf_op_t    op;
    logic [7:0] opnd;
    logic [1:0] len;
    logic [7:0] acc;
    logic [7:0] x;
    logic [7:0] flags;
    logic       tk;
  } urf_row_t;
  logic        mclk_in = 1'b0;
  logic        rst_in = 1'b1;
  logic        ce_in = 1'b1;
  logic        op_valid_in = 1'b0;
  urf_op_t     op_in = URF_NOP;
  urf_idx_t    idx_sel_in = URF_IDX_NONE;
  logic [7:0]  operand_in = 8'h00;
  logic [15:0] base_addr_in = 16'h0000;
  logic [1:0]  op_len_in = 2'h1;
  logic [15:0] vector_in = 16'hC000;
  logic [7:0]  mem_rdata_in;
  logic        irq_in = 1'b0;
  logic        ready_out, mem_we_out, branch_taken_out;
  logic [7:0]  acc_out, x_out, y_out, flags_out, sp_out, mem_wdata_out;
  logic [15:0] pc_out, mem_addr_out, pc_e;
  int          fails = 0;
  int          checks_done = 0;
  urf_row_t    rows [24] = '{
    '{URF_CLEAR_MASK, 8'h00, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0},
    '{URF_SET_CARRY, 8'h00, 2'h1, 8'h00, 8'h00, 8'h01, 1'b0},
    '{URF_SET_DECIMAL, 8'h00, 2'h1, 8'h00, 8'h00, 8'h09, 1'b0},
    '{URF_CLEAR_DECIMAL, 8'h00, 2'h1, 8'h00, 8'h00, 8'h01, 1'b0},
    '{URF_CLEAR_CARRY, 8'h00, 2'h1, 8'h00, 8'h00, 8'h00, 1'b0},
    '{URF_LOAD_ACC, 8'h7F, 2'h2, 8'h7F, 8'h00, 8'h00, 1'b0},
    '{URF_ADD, 8'h01, 2'h2, 8'h80, 8'h00, 8'hC0, 1'b0},
    '{URF_BR_NEG, 8'h04, 2'h2, 8'h80, 8'h00, 8'hC0, 1'b1},
    '{URF_BR_POS, 8'h04, 2'h2, 8'h80, 8'h00, 8'hC0, 1'b0},
    '{URF_BR_OVF_SET, 8'hFC, 2'h2, 8'h80, 8'h00, 8'hC0, 1'b1},
    '{URF_BR_OVF_CLEAR, 8'h04, 2'h2, 8'h80, 8'h00, 8'hC0, 1'b0},
    '{URF_CLEAR_OVERFLOW, 8'h00, 2'h1, 8'h80, 8'h00, 8'h80, 1'b0},
    '{URF_ADD, 8'h80, 2'h2, 8'h00, 8'h00, 8'h43, 1'b0},
    '{URF_BR_ZERO, 8'h10, 2'h2, 8'h00, 8'h00, 8'h43, 1'b1},
    '{URF_BR_NONZERO, 8'h10, 2'h2, 8'h00, 8'h00, 8'h43, 1'b0},
    '{URF_CLEAR_CARRY, 8'h00, 2'h1, 8'h00, 8'h00, 8'h42, 1'b0},
    '{URF_CLEAR_OVERFLOW, 8'h00, 2'h1, 8'h00, 8'h00, 8'h02, 1'b0},
    '{URF_LOAD_ACC, 8'h05, 2'h2, 8'h05, 8'h00, 8'h00, 1'b0},
    '{URF_COPY_ACC_X, 8'h00, 2'h1, 8'h05, 8'h05, 8'h00, 1'b0},
    '{URF_INC_X, 8'h00, 2'h1, 8'h05, 8'h06, 8'h00, 1'b0},
    '{URF_COMPARE_X, 8'h06, 2'h2, 8'h05, 8'h06, 8'h03, 1'b0},
    '{URF_SET_MASK, 8'h00, 2'h1, 8'h05, 8'h06, 8'h07, 1'b0},
    '{URF_BIT_TEST, 8'hC0, 2'h2, 8'h05, 8'h06, 8'hC7, 1'b0},
    '{URF_CLEAR_OVERFLOW, 8'h00, 2'h1, 8'h05, 8'h06, 8'h87, 1'b0}};

  urf_core urf_core_inst (.mclk_in(mclk_in), .rst_in(rst_in), .ce_in(ce_in),
    .op_valid_in(op_valid_in), .op_in(op_in), .idx_sel_in(idx_sel_in),
    .operand_in(operand_in), .base_addr_in(base_addr_in), .op_len_in(op_len_in),
    .vector_in(vector_in), .mem_rdata_in(mem_rdata_in), .irq_in(irq_in),
    .ready_out(ready_out), .acc_out(acc_out), .x_out(x_out), .y_out(y_out),
    .flags_out(flags_out), .sp_out(sp_out), .pc_out(pc_out), .mem_addr_out(mem_addr_out),
    .mem_wdata_out(mem_wdata_out), .mem_we_out(mem_we_out),
    .branch_taken_out(branch_taken_out));
  urf_mem_model urf_mem_model_inst (.mclk_in(mclk_in), .addr_in(mem_addr_out),
    .wdata_in(mem_wdata_out), .we_in(mem_we_out), .rdata_out(mem_rdata_in));

  initial begin
    forever #5 mclk_in = ~mclk_in;
  end

  // ----------------------------------------
  // Bus helpers
  // ----------------------------------------
  task automatic wait_ready();
    for (int n = 0; n < 50 && ready_out !== 1'b1; n++) @(negedge mclk_in);
    if (ready_out !== 1'b1) begin
      fails++;
      $display("Error at %0t: ready never returned", $time);
    end
  endtask

  // Offers one op at a falling edge; ready is high then and nothing else can drop it.
  task automatic do_op(input urf_op_t op, input urf_idx_t idx, input logic [7:0] opnd,
                       input logic [15:0] base, input logic [1:0] len, input logic chk,
                       input logic tk);
    @(negedge mclk_in);
    wait_ready();
    op_in = op;
    idx_sel_in = idx;
    operand_in = opnd;
    base_addr_in = base;
    op_len_in = len;
    op_valid_in = 1'b1;
    @(negedge mclk_in);
    op_valid_in = 1'b0;
    if (chk) begin
      pc_e = pc_e + 16'(len) + (tk ? {{8{opnd[7]}}, opnd} : 16'h0000);
      `CHK(branch_taken_out, tk)
      `CHK(pc_out, pc_e)
    end
  endtask

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  initial begin
    #100000;
    fails++;
    report_and_stop();
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [15:0] pc_b;
    repeat (6) @(negedge mclk_in);
    `CHK({acc_out, x_out, y_out}, {3{DATA_RESET}})
    `CHK({flags_out, sp_out, pc_out}, {FLAGS_RESET, SP_RESET, PC_RESET})
    `CHK({mem_we_out, ready_out}, 2'b00)
    rst_in = 1'b0;
    pc_e = PC_RESET;
    $display("reset test done");
    foreach (rows[i]) begin
      do_op(rows[i].op, URF_IDX_NONE, rows[i].opnd, 16'h0000, rows[i].len, 1'b1, rows[i].tk);
      `CHK(acc_out, rows[i].acc)
      `CHK(x_out, rows[i].x)
      `CHK(flags_out, rows[i].flags)
    end
    $display("row test done");
    // Clears 0x0400 to 0x040A with an indexed store loop closed by a nonzero branch.
    do_op(URF_LOAD_ACC, URF_IDX_NONE, 8'h00, 16'h0000, 2'h2, 1'b1, 1'b0);
    do_op(URF_COPY_ACC_X, URF_IDX_NONE, 8'h00, 16'h0000, 2'h1, 1'b1, 1'b0);
    for (int i = 0; i < 11; i++) begin
      do_op(URF_STORE_ACC, URF_IDX_X, 8'h00, 16'h0400, 2'h3, 1'b1, 1'b0);
      do_op(URF_INC_X, URF_IDX_NONE, 8'h00, 16'h0000, 2'h1, 1'b1, 1'b0);
      do_op(URF_COMPARE_X, URF_IDX_NONE, 8'h0B, 16'h0000, 2'h2, 1'b1, 1'b0);
      do_op(URF_BR_NONZERO, URF_IDX_NONE, 8'hF8, 16'h0000, 2'h2, 1'b1, i < 10);
    end
    do_op(URF_LOAD_X, URF_IDX_NONE, 8'h21, 16'h0000, 2'h2, 1'b1, 1'b0);
    do_op(URF_STORE_X, URF_IDX_NONE, 8'h00, 16'h0501, 2'h3, 1'b1, 1'b0);
    do_op(URF_LOAD_Y, URF_IDX_NONE, 8'h3C, 16'h0000, 2'h2, 1'b1, 1'b0);
    do_op(URF_STORE_Y, URF_IDX_Y, 8'h00, 16'h0500, 2'h3, 1'b1, 1'b0);
    @(negedge mclk_in);
    `CHK(urf_mem_model_inst.mem[16'h040A], 8'h00)
    `CHK(urf_mem_model_inst.mem[16'h040B], 8'hA5)
    `CHK(urf_mem_model_inst.mem[16'h0501], 8'h21)
    `CHK(urf_mem_model_inst.mem[16'h053C], 8'h3C)
    $display("store test done");
    pc_b = pc_e;
    do_op(URF_CALL, URF_IDX_NONE, 8'h00, 16'h1234, 2'h3, 1'b0, 1'b0);
    wait_ready();
    `CHK({pc_out, sp_out}, {16'h1234, 8'hFD})
    do_op(URF_RETURN, URF_IDX_NONE, 8'h00, 16'h0000, 2'h1, 1'b0, 1'b0);
    wait_ready();
    pc_e = {urf_mem_model_inst.mem[16'h01FF], urf_mem_model_inst.mem[16'h01FE]};
    `CHK({pc_out, sp_out}, {pc_e, 8'hFF})
    `CHK(pc_e, pc_b + 16'h0003)
    $display("call test done");
    do_op(URF_CLEAR_MASK, URF_IDX_NONE, 8'h00, 16'h0000, 2'h1, 1'b1, 1'b0);
    irq_in = 1'b1;
    for (int n = 0; n < 20 && ready_out !== 1'b0; n++) @(negedge mclk_in);
    wait_ready();
    irq_in = 1'b0;
    `CHK({pc_out, sp_out, flags_out}, {vector_in, 8'hFC, 8'h05})
    // The flag push lands in memory one edge after ready returns.
    @(negedge mclk_in);
    `CHK(urf_mem_model_inst.mem[16'h01FF], pc_e[15:8])
    `CHK(urf_mem_model_inst.mem[16'h01FE], pc_e[7:0])
    `CHK(urf_mem_model_inst.mem[16'h01FD], 8'h01)
    pc_e = vector_in;
    vector_in = 16'hE000;
    $display("interrupt test done");
    do_op(URF_BREAK, URF_IDX_NONE, 8'h00, 16'h0000, 2'h1, 1'b0, 1'b0);
    wait_ready();
    `CHK({pc_out, sp_out, flags_out}, {16'hE000, 8'hF9, 8'h15})
    @(negedge mclk_in);
    `CHK(urf_mem_model_inst.mem[16'h01FC], 8'hC0)
    `CHK(urf_mem_model_inst.mem[16'h01FB], 8'h02)
    `CHK(urf_mem_model_inst.mem[16'h01FA], 8'h15)
    $display("break test done");
    // With the clock enable low an offered op must leave every register alone.
    ce_in = 1'b0;
    op_in = URF_LOAD_ACC;
    operand_in = 8'h77;
    op_valid_in = 1'b1;
    repeat (3) @(negedge mclk_in);
    `CHK({acc_out, pc_out}, {8'h00, 16'hE000})
    op_valid_in = 1'b0;
    ce_in = 1'b1;
    rst_in = 1'b1;
    repeat (2) @(negedge mclk_in);
    `CHK({flags_out, sp_out, pc_out}, {FLAGS_RESET, SP_RESET, PC_RESET})
    rst_in = 1'b0;
    $display("freeze and reset test done");
    report_and_stop();
  end
endmodule
